// ==== design/ccg_pkg.sv ====
// Purpose: Shared constants and types for the system clock control block
// Assumes: 20 MHz control clock; registers reached over Avalon-MM
// Notes: Summary of operation follows
package ccg_pkg;
  // Register byte offsets
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] LPD_OFS = 5'h04;
  localparam logic [4:0] WDOG_OFS = 5'h08;
  localparam logic [4:0] STAT_OFS = 5'h0c;
  // Control register field positions
  localparam int SRC_POS = 0;
  localparam int ONE_POS = 2;
  localparam int MULT_POS = 3;
  localparam int RFD_POS = 8;
  localparam int FAST_POS = 11;
  localparam int STOP_POS = 12;
  // Values after reset, and the factor limit
  localparam logic [4:0] MULT_RST = 5'h01;
  localparam logic [2:0] RFD_RST = 3'h0;
  localparam logic [1:0] STOP_RST = 2'h0;
  localparam logic [3:0] LPD_RST = 4'h0;
  localparam logic [4:0] MULT_MAX = 5'h12;
  // Power controller mode codes
  localparam logic [1:0] LP_RUN = 2'h0;
  localparam logic [1:0] LP_WAIT = 2'h1;
  localparam logic [1:0] LP_DOZE = 2'h2;
  localparam logic [1:0] LP_STOP = 2'h3;
  // Wakeup times in microseconds and their cycle counts
  localparam int CLK_KHZ = 20000;
  localparam int RELOCK_US = 100;
  localparam int RESTART_US = 200;
  localparam logic [12:0] RELOCK_CYC = 13'((RELOCK_US * CLK_KHZ + 999) / 1000);
  localparam logic [12:0] RESTART_CYC = 13'((RESTART_US * CLK_KHZ + 999) / 1000);
  localparam logic [1:0] CFG_WAIT = 2'h3;

  typedef enum logic [1:0] {SRC_PLL, SRC_CRYSTAL_DRIVE_PIN, SRC_RELAX, SRC_EXT} ccg_src_t;

  typedef struct packed {
    logic [1:0] stop_pll_setting;
    logic fast_wakeup;
    logic [2:0] reduced_freq_divider;
    logic [4:0] mult;
    logic one_to_one;
    ccg_src_t src;
  } ccg_ctrl_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } ccg_avs_req_t;
endpackage : ccg_pkg

// ==== design/ccg_sync.sv ====
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk_in
// Notes: First stage read only by the second
`timescale 1ns/100ps
`default_nettype none
module ccg_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two flops against metastability
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule : ccg_sync
`default_nettype wire

// ==== design/ccg_lpdiv.sv ====
// Purpose: Power-of-two low-power divider producing a clock tick
// Assumes: Exponent 0..15 from a register
// Notes: New exponent taken only at a period boundary
`timescale 1ns/100ps
`default_nettype none
module ccg_lpdiv #(
  parameter int EW = 4
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [EW-1:0] exp_in,
  output logic tick_out
);
  localparam int CW = 2 ** EW;
  logic [CW-1:0] cnt_q;
  logic [EW-1:0] exp_q;
  logic [CW-1:0] last;
  logic wrap;

  assign last = CW'((64'h1 << exp_q) - 64'h1);
  assign wrap = (cnt_q == last);
  assign tick_out = wrap;

  // Reloading only at wrap avoids runt periods
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
      exp_q <= '0;
    end else if (wrap) begin
      cnt_q <= '0;
      exp_q <= exp_in;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule : ccg_lpdiv
`default_nettype wire

// ==== design/ccg_top.sv ====
// Purpose: System clock source, divider and low-power gating control
// Assumes: Power controller and module gates on clk_in; straps are pins
// Notes: Clocks are modelled as enable ticks toward clock gates
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ccg_top #(
  parameter int NPER = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire ccg_pkg::ccg_avs_req_t avs_req_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [1:0] clock_mode_select_in,
  input wire logic crystal_drive_pin_in,
  input wire logic pll_lock_in,
  input wire logic [1:0] lp_mode_in,
  input wire logic [NPER-1:0] periph_gate_in,
  output logic [1:0] clk_src_sel_out,
  output logic [4:0] pll_mult_out,
  output logic [2:0] pll_post_div_out,
  output logic pll_power_out,
  output logic osc_power_out,
  output logic cpu_clk_en_out,
  output logic sram_clk_en_out,
  output logic [NPER-1:0] periph_clk_en_out,
  output logic system_clock_output_out,
  output logic wdog_en_out,
  output logic wdog_src_relax_out
);
  import ccg_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_LIGHT, ST_STOP, ST_WAKE} ccg_state_t;

  ccg_state_t state_q;
  ccg_state_t state_d;
  ccg_ctrl_t ctrl_q;
  ccg_src_t src_act_q;
  logic [4:0] mult_act_q;
  logic [2:0] rfd_act_q;
  logic [3:0] lpd_q;
  logic wdog_en_q;
  logic wdog_relax_q;
  logic wdog_lock_q;
  logic cfg_done_q;
  logic [1:0] cfg_cnt_q;
  logic pll_en_q;
  logic ext_mode_q;
  logic [12:0] wake_cnt_q;
  logic [12:0] wake_cnt_d;
  logic ack_q;
  logic [31:0] rdata_q;
  logic system_clock_output_q;
  logic [2:0] pins_s;
  logic lock_s;
  logic sys_tick;
  logic req;
  logic wr_ctrl;
  logic wr_lpd;
  logic wr_wdog;
  logic [31:0] rdata_d;
  ccg_ctrl_t wctrl;
  logic relax_block;
  ccg_src_t src_new;
  logic [4:0] mult_clamp;
  logic [4:0] mult_eff;
  logic [2:0] rfd_eff;
  logic run_cpu;
  logic run_per;
  logic system_clock_output_run;
  logic pll_kept;
  logic osc_kept;

  // Straps and lock come from pins
  ccg_sync #(.W(3)) u_pin_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .d_in({clock_mode_select_in, crystal_drive_pin_in}),
    .q_out(pins_s)
  );

  ccg_sync #(.W(1)) u_lock_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .d_in(pll_lock_in),
    .q_out(lock_s)
  );

  // System clock rate set by the low-power divider
  ccg_lpdiv #(.EW(4)) u_lpdiv (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .exp_in(lpd_q),
    .tick_out(sys_tick)
  );

  // Bus decode; one wait cycle then answer
  assign req = avs_req_in.read | avs_req_in.write;
  assign avs_waitrequest_out = req & ~ack_q;
  assign wr_ctrl = avs_req_in.write & ack_q & (avs_req_in.address == CTRL_OFS);
  assign wr_lpd = avs_req_in.write & ack_q & (avs_req_in.address == LPD_OFS);
  assign wr_wdog = avs_req_in.write & ack_q & (avs_req_in.address == WDOG_OFS);
  assign wctrl = ccg_ctrl_t'(avs_req_in.writedata[13:0]);

  // Relax source refused once the watchdog owns it, unless the system already runs from it
  assign relax_block = wdog_relax_q & (src_act_q != SRC_RELAX);
  assign src_new = (wctrl.src == SRC_RELAX && relax_block) ? ctrl_q.src : wctrl.src;

  // Factor limited to 1x..18x
  assign mult_clamp = (ctrl_q.mult == 5'h00) ? 5'h01 :
                      (ctrl_q.mult > MULT_MAX) ? MULT_MAX : ctrl_q.mult;
  assign mult_eff = ctrl_q.one_to_one ? 5'h01 : mult_clamp;
  assign rfd_eff = ctrl_q.one_to_one ? 3'h0 : ctrl_q.reduced_freq_divider;

  // Read multiplexer; unmapped reads give zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (avs_req_in.address)
      CTRL_OFS: rdata_d = {18'h0, ctrl_q};
      LPD_OFS: rdata_d = {28'h0, lpd_q};
      WDOG_OFS: rdata_d = {29'h0, wdog_lock_q, wdog_relax_q, wdog_en_q};
      STAT_OFS: rdata_d = {23'h0, relax_block, pll_en_q, ext_mode_q,
                           (state_q == ST_WAKE), lock_s, state_q, src_act_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Bus answer flops
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_req_in.read & ~ack_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign avs_readdata_out = rdata_q;

  // Strap capture once synchronised values settle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_cnt_q <= 2'h0;
      cfg_done_q <= 1'b0;
      pll_en_q <= 1'b0;
      ext_mode_q <= 1'b0;
    end else if (!cfg_done_q) begin
      cfg_cnt_q <= cfg_cnt_q + 2'h1;
      if (cfg_cnt_q == CFG_WAIT) begin
        cfg_done_q <= 1'b1;
        pll_en_q <= pins_s[2];
        ext_mode_q <= ~pins_s[2] & ~pins_s[1] & ~pins_s[0];
      end
    end
  end

  // Control and divider registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= '{stop_pll_setting: STOP_RST, fast_wakeup: 1'b0,
                  reduced_freq_divider: RFD_RST, mult: MULT_RST,
                  one_to_one: 1'b0, src: SRC_PLL};
      lpd_q <= LPD_RST;
    end else if (!cfg_done_q && cfg_cnt_q == CFG_WAIT) begin
      // Initial source from straps
      if (pins_s[2]) begin
        ctrl_q.src <= SRC_PLL;
      end else if (pins_s[1]) begin
        ctrl_q.src <= SRC_CRYSTAL_DRIVE_PIN;
      end else begin
        ctrl_q.src <= pins_s[0] ? SRC_RELAX : SRC_EXT;
      end
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wctrl;
        ctrl_q.src <= src_new;
      end
      if (wr_lpd) begin
        lpd_q <= avs_req_in.writedata[3:0];
      end
    end
  end

  // Watchdog source written once per reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wdog_en_q <= 1'b0;
      wdog_relax_q <= 1'b0;
      wdog_lock_q <= 1'b0;
    end else if (wr_wdog && !wdog_lock_q) begin
      wdog_en_q <= avs_req_in.writedata[0];
      wdog_relax_q <= avs_req_in.writedata[1];
      wdog_lock_q <= 1'b1;
    end
  end

  assign wdog_en_out = wdog_en_q;
  assign wdog_src_relax_out = wdog_relax_q;

  // Settings applied at a divider boundary, never mid-period
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      src_act_q <= SRC_PLL;
      mult_act_q <= MULT_RST;
      rfd_act_q <= RFD_RST;
    end else if (sys_tick && cfg_done_q) begin
      src_act_q <= ctrl_q.src;
      mult_act_q <= mult_eff;
      rfd_act_q <= rfd_eff;
    end
  end

  assign clk_src_sel_out = src_act_q;
  assign pll_mult_out = mult_act_q;
  assign pll_post_div_out = rfd_act_q;

  // Stop-mode power choices: 00 all on, 01 PLL off, 1x both off
  assign pll_kept = (ctrl_q.stop_pll_setting == 2'h0);
  assign osc_kept = ~ctrl_q.stop_pll_setting[1];
  assign pll_power_out = pll_en_q & ~ext_mode_q & ((state_q != ST_STOP) | pll_kept);
  assign osc_power_out = ~ext_mode_q & ((state_q != ST_STOP) | osc_kept);

  // Low-power sequencing
  always_comb begin
    state_d = state_q;
    wake_cnt_d = wake_cnt_q;
    case (state_q)
      ST_RUN: begin
        if (lp_mode_in == LP_STOP) begin
          state_d = ST_STOP;
        end else if (lp_mode_in == LP_WAIT || lp_mode_in == LP_DOZE) begin
          state_d = ST_LIGHT;
        end
      end
      ST_LIGHT: begin
        if (lp_mode_in == LP_RUN) begin
          state_d = ST_RUN;
        end else if (lp_mode_in == LP_STOP) begin
          state_d = ST_STOP;
        end
      end
      ST_STOP: begin
        if (lp_mode_in != LP_STOP) begin
          if (ext_mode_q || ctrl_q.fast_wakeup || pll_kept) begin
            state_d = ST_RUN;
          end else begin
            state_d = ST_WAKE;
            wake_cnt_d = osc_kept ? RELOCK_CYC : RESTART_CYC;
          end
        end
      end
      ST_WAKE: begin
        if (wake_cnt_q <= 13'h0001) begin
          state_d = ST_RUN;
          wake_cnt_d = 13'h0000;
        end else begin
          wake_cnt_d = wake_cnt_q - 13'h0001;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_RUN;
      wake_cnt_q <= 13'h0000;
    end else begin
      state_q <= state_d;
      wake_cnt_q <= wake_cnt_d;
    end
  end

  // Clock enables; held off until straps are known
  assign run_cpu = cfg_done_q & (state_q == ST_RUN);
  assign run_per = cfg_done_q & ((state_q == ST_RUN) | (state_q == ST_LIGHT));
  assign cpu_clk_en_out = run_cpu & sys_tick;
  assign sram_clk_en_out = run_cpu & sys_tick;

  // Local gates act on top of the central gating
  genvar gi;
  generate
    for (gi = 0; gi < NPER; gi++) begin : g_per
      assign periph_clk_en_out[gi] = run_per & sys_tick & ~periph_gate_in[gi];
    end
  endgenerate

  // Clock output keeps toggling in stop while the PLL runs
  assign system_clock_output_run = run_per | (cfg_done_q & (state_q == ST_STOP) & pll_kept);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      system_clock_output_q <= 1'b0;
    end else if (system_clock_output_run && sys_tick) begin
      system_clock_output_q <= ~system_clock_output_q;
    end
  end

  assign system_clock_output_out = system_clock_output_q;
endmodule : ccg_top
`default_nettype wire

// ==== verification/ccg_monitor.sv ====
// Purpose: Port checker for the clock control block
// Assumes: Sees only the top module ports
// Notes: Bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module ccg_monitor import ccg_pkg::*; #(
  parameter int NPER = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire ccg_pkg::ccg_avs_req_t avs_req_in,
  input wire logic avs_waitrequest_out,
  input wire logic [1:0] lp_mode_in,
  input wire logic [NPER-1:0] periph_gate_in,
  input wire logic [1:0] clk_src_sel_out,
  input wire logic [4:0] pll_mult_out,
  input wire logic cpu_clk_en_out,
  input wire logic sram_clk_en_out,
  input wire logic [NPER-1:0] periph_clk_en_out,
  input wire logic wdog_en_out,
  input wire logic wdog_src_relax_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Named levels; three cycles cover the state and enable delays
  wire logic low_w = (lp_mode_in == LP_WAIT) || (lp_mode_in == LP_DOZE);
  wire logic stop_w = lp_mode_in == LP_STOP;
  wire logic req_w = avs_req_in.read || avs_req_in.write;
  chk_bus_one_wait: assert property ($rose(req_w) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("bus wait not exactly one cycle");
  chk_wdog_reset_off: assert property ($rose(rstn_in) |-> !wdog_en_out && !wdog_src_relax_out)
    else $error("watchdog not off after reset");
  chk_wdog_set_once: assert property ((wdog_en_out || wdog_src_relax_out) |=>
    $stable({wdog_en_out, wdog_src_relax_out})) else $error("watchdog setting changed");
  chk_relax_sys_blocked: assert property (wdog_src_relax_out && clk_src_sel_out != SRC_RELAX
    |=> clk_src_sel_out != SRC_RELAX) else $error("relax source taken while blocked");
  chk_mult_in_range: assert property (1'b1 |-> pll_mult_out inside {[5'h01:5'h12]})
    else $error("factor out of range");
  chk_low_core_off: assert property (low_w [*3] |-> !cpu_clk_en_out && !sram_clk_en_out)
    else $error("core clock in wait or doze");
  chk_stop_all_off: assert property (stop_w [*3] |->
    !(cpu_clk_en_out || sram_clk_en_out || (|periph_clk_en_out))) else $error("clock in stop");
  chk_gate_local_off: assert property ($stable(periph_gate_in) |->
    (periph_clk_en_out & periph_gate_in) == '0) else $error("gated module clocked");
  cover property ($rose(wdog_en_out));
  cover property (stop_w [*8]);
  cover property (clk_src_sel_out == SRC_EXT);
endmodule : ccg_monitor
`default_nettype wire

// ==== verification/ccg_osc_model.sv ====
// Purpose: Oscillator and PLL model at the far side
// Assumes: Lock follows PLL power on the control clock
// Notes: Lock is lost at the first clock edge after power drops
`timescale 1ns/100ps
`default_nettype none
module ccg_osc_model (
  input wire logic clk_in,
  input wire logic pll_power_in,
  output logic pll_lock_out
);
  logic [4:0] cnt_q;
  // Settling count; the block must not trust lock early
  always_ff @(posedge clk_in) begin
    if (!pll_power_in) cnt_q <= 5'h00;
    else if (cnt_q != 5'h1f) cnt_q <= cnt_q + 5'h01;
  end
  assign pll_lock_out = cnt_q == 5'h1f;
endmodule : ccg_osc_model
`default_nettype wire

// ==== verification/ccg_top_tb.sv ====
// Purpose: Self-checking bench for the clock control block
// Assumes: Straps set while reset is low
// Notes: Reads are checked by a watcher from a queue
`timescale 1ns/100ps
`default_nettype none
module ccg_top_tb_top;
  import ccg_pkg::*;
  localparam int NPER = 8;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  ccg_avs_req_t req = '0;
  logic [1:0] mode = 2'h2;
  logic crystal_drive_pin = 1'b0;
  logic [1:0] lp = LP_RUN;
  logic [NPER-1:0] gate = '0;
  logic [NPER-1:0] gate_q = '0;
  logic [31:0] rdata;
  logic wreq, pwr, opwr, lock, sck, sck_q, wen, wrel, cpu, sram;
  logic [1:0] src;
  logic [4:0] mult;
  logic [2:0] pdiv;
  logic [NPER-1:0] pen;
  int failures = 0, checks_done = 0, cyc = 0, cpu_n = 0, per_n = 0, tog_n = 0, gate_bad = 0;
  logic [31:0] exp_q[$];
  ccg_top #(.NPER(NPER)) ccg_top_inst (.clk_in(clk_in), .rstn_in(rstn_in), .avs_req_in(req),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .clock_mode_select_in(mode),
    .crystal_drive_pin_in(crystal_drive_pin), .pll_lock_in(lock), .lp_mode_in(lp), .periph_gate_in(gate),
    .clk_src_sel_out(src), .pll_mult_out(mult), .pll_post_div_out(pdiv), .pll_power_out(pwr),
    .osc_power_out(opwr), .cpu_clk_en_out(cpu), .sram_clk_en_out(sram),
    .periph_clk_en_out(pen), .system_clock_output_out(sck), .wdog_en_out(wen),
    .wdog_src_relax_out(wrel));
  ccg_osc_model ccg_osc_model_inst (.clk_in(clk_in), .pll_power_in(pwr), .pll_lock_out(lock));
  initial forever #25 clk_in = ~clk_in;
  task automatic cmp(input logic [31:0] e, input logic [31:0] g, input string n);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // Tallies, read watcher and hang limit; counts lag one edge
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    cpu_n <= cpu_n + cpu;
    per_n <= per_n + (|pen);
    sck_q <= sck;
    tog_n <= tog_n + (sck !== sck_q);
    gate_q <= gate;
    gate_bad <= gate_bad + (|(pen & gate & gate_q));
    if (req.read && wreq === 1'b0) cmp(exp_q.pop_front(), rdata, "readdata");
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  // Request held until waitrequest is sampled low
  task automatic bus(input logic r, input logic [4:0] a, input logic [31:0] d);
    req <= {r, !r, a, d};
    @(posedge clk_in iff wreq === 1'b0);
    req <= '0;
    @(posedge clk_in);
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b1, a, 32'h0);
  endtask : rd
  function automatic logic [31:0] cw(input logic [1:0] sp, input logic f, input logic [2:0] r,
    input logic [4:0] m, input logic o, input logic [1:0] s);
    return {18'h0, sp, f, r, m, o, s};
  endfunction : cw
  task automatic rst(input logic [1:0] m, input logic x);
    rstn_in <= 1'b0;
    mode <= m;
    crystal_drive_pin <= x;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask : rst
  task automatic pulse(output int n);
    int c;
    c = cpu_n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (cpu_n == c && n < 6000);
  endtask : pulse
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    @(negedge clk_in);
    cmp(e, g, n);
    @(posedge clk_in);
  endtask : chk
  // Stop with a given setting, then time the return of core clocks
  task automatic wake(input logic [1:0] sp, input logic f, input int lo, input int hi,
    input logic [1:0] s);
    int c, p, t, n;
    bus(1'b0, CTRL_OFS, cw(sp, f, {2'h0, f}, 5'h01, 1'b0, s));
    lp <= LP_STOP;
    repeat (4) @(posedge clk_in);
    c = cpu_n;
    p = per_n;
    t = tog_n;
    repeat (8) @(posedge clk_in);
    cmp(0, cpu_n - c + per_n - p, "stop clocks");
    cmp({s != SRC_EXT && sp == 2'h0, s != SRC_EXT && !sp[1]}, {pwr, opwr}, "stop power");
    if (s == SRC_PLL) cmp(sp == 2'h0, tog_n > t, "clock out in stop");
    lp <= LP_RUN;
    pulse(n);
    cmp(1, n >= lo && n <= hi, "wake time");
  endtask : wake
  initial begin
    int n, c, p;
    logic [4:0] m;
    void'($urandom(32'hc769));
    rst(2'h2, 1'b0);
    chk(0, {wen, wrel}, "watchdog reset");
    rd(CTRL_OFS, 32'h8);
    rd(5'h10, 32'h0);
    rd(LPD_OFS, 32'h0);
    repeat (3) begin
      m = 5'(1 + $urandom % 18);
      bus(1'b0, CTRL_OFS, cw(2'h0, 1'b0, 3'h0, m, 1'b0, SRC_PLL));
      rd(CTRL_OFS, cw(2'h0, 1'b0, 3'h0, m, 1'b0, SRC_PLL));
      chk(m, mult, "factor");
    end
    m = 5'(19 + $urandom % 13);
    bus(1'b0, CTRL_OFS, cw(2'h0, 1'b0, 3'h0, m, 1'b0, SRC_PLL));
    repeat (2) @(posedge clk_in);
    chk(MULT_MAX, mult, "factor limit");
    for (int o = 1; o >= 0; o--) begin
      bus(1'b0, CTRL_OFS, cw(2'h0, 1'b0, 3'h3, 5'h05, o[0], o[0] ? SRC_PLL : SRC_CRYSTAL_DRIVE_PIN));
      repeat (3) @(posedge clk_in);
      chk(o ? 1 : 5, mult, "factor one");
      chk(o ? 0 : 3, pdiv, "post divider");
      chk(o ? SRC_PLL : SRC_CRYSTAL_DRIVE_PIN, src, "source");
    end
    bus(1'b0, CTRL_OFS, cw(2'h0, 1'b0, 3'h0, 5'h01, 1'b0, SRC_PLL));
    $display("done: registers");
    for (int i = 1; i <= 2; i++) begin
      lp <= 2'(i);
      gate <= 8'(($urandom | 1) & 8'h7f);
      repeat (4) @(posedge clk_in);
      c = cpu_n;
      p = per_n;
      repeat (16) @(posedge clk_in);
      cmp(0, cpu_n - c, "core clocks");
      cmp(1, per_n > p, "periph clocks");
    end
    lp <= LP_RUN;
    gate <= '0;
    pulse(n);
    cmp(0, gate_bad, "gated clocks");
    $display("done: wait and doze");
    for (int e = 1; e <= 4; e += 3) begin
      bus(1'b0, LPD_OFS, 32'(e));
      repeat (3) pulse(n);
      cmp(1 << e, n, "divider period");
    end
    bus(1'b0, LPD_OFS, 32'h0);
    $display("done: divider");
    rd(STAT_OFS, 32'h90);
    wake(2'h0, 1'b0, 0, 8, SRC_PLL);
    wake(2'h1, 1'b0, 2000, 2010, SRC_PLL);
    wake(2'h2, 1'b0, 4000, 4010, SRC_PLL);
    wake(2'h1, 1'b1, 0, 8, SRC_PLL);
    $display("done: stop and wake");
    bus(1'b0, WDOG_OFS, 32'h3);
    bus(1'b0, CTRL_OFS, cw(2'h0, 1'b0, 3'h0, 5'h01, 1'b0, SRC_RELAX));
    bus(1'b0, WDOG_OFS, 32'h0);
    rd(CTRL_OFS, 32'h8);
    rd(WDOG_OFS, 32'h7);
    chk(3, {wen, wrel}, "watchdog");
    rst(2'h0, 1'b1);
    chk(SRC_RELAX, src, "relax strap");
    bus(1'b0, WDOG_OFS, 32'h3);
    chk({SRC_RELAX, 1'b1}, {src, wrel}, "shared relax");
    rst(2'h0, 1'b0);
    chk(SRC_EXT, src, "external strap");
    wake(2'h2, 1'b0, 0, 8, SRC_EXT);
    rst(2'h1, 1'b0);
    chk(SRC_CRYSTAL_DRIVE_PIN, src, "crystal strap");
    $display("done: watchdog and straps");
    test_done();
  end
endmodule : ccg_top_tb_top
bind ccg_top ccg_monitor #(.NPER(NPER)) ccg_monitor_inst (.clk_in(clk_in), .rstn_in(rstn_in),
  .avs_req_in(avs_req_in), .avs_waitrequest_out(avs_waitrequest_out), .lp_mode_in(lp_mode_in),
  .periph_gate_in(periph_gate_in), .clk_src_sel_out(clk_src_sel_out),
  .pll_mult_out(pll_mult_out), .cpu_clk_en_out(cpu_clk_en_out),
  .sram_clk_en_out(sram_clk_en_out), .periph_clk_en_out(periph_clk_en_out),
  .wdog_en_out(wdog_en_out), .wdog_src_relax_out(wdog_src_relax_out));
`default_nettype wire
